// ### hdl/bcr_config.sv
// Functional notes
// R1: bit 0 connects discharge only while disabled
// R2: bit 1 keeps discharge always disconnected
// R3: fpwm clear allows automatic light-load pulse skipping
// R4: fpwm set forbids pulse skipping entirely
// R5: software writes zero to reserved bit one
// R6: low-power mode ignores falling-slew discharge bit
// R7: falling-slew enabled forces fixed frequency, 50us hold
// R8: falling-slew disabled allows skip on ramp-down
// R9: second register at 0x22, reset 0x07
// R10: software writes zeros to reserved fields
// R11: bit two senses converter zero, off in low-power
// R12: bit one senses converter one, off in low-power
// R13: ramp field decodes to four slew rates
// R14: discharge switch follows enable combinationally
`timescale 1ns/1ps
`include "bcr_regs.svh"
module bcr_config #(
    parameter int NCONV    = 4,
    parameter int HOLD_CYC = `BCR_HOLD_NS / `BCR_CLK_NS,
    parameter logic [7:0] CFG1_RESET = `BCR_CFG1_RESET
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // register port
    input  wire bcr_pkg::bcr_req_s    req,
    output logic [7:0]                rdata,
    // converter state
    input  wire bcr_pkg::bcr_conv_s   conv [NCONV],
    // converter controls
    output logic [NCONV-1:0]          discharge_on,
    output logic [NCONV-1:0]          pulse_skip_en,
    output logic [1:0]                remote_output_sensing,
    output bcr_pkg::bcr_rate_t        ramp_rate [NCONV]
);
    import bcr_pkg::*;

    localparam logic [13:0] HOLD = 14'(HOLD_CYC);

    function automatic bcr_rate_t rate_decode(input logic [1:0] sel);
        unique case (sel)
            2'h0: rate_decode = `BCR_RATE_0;
            2'h1: rate_decode = `BCR_RATE_1;
            2'h2: rate_decode = `BCR_RATE_2;
            2'h3: rate_decode = `BCR_RATE_3;
        endcase
    endfunction : rate_decode

    logic [7:0] cfg1_reg [NCONV];
    logic [7:0] cfg2_reg;
    logic [7:0] rdata_next;
    logic [13:0] hold_reg [NCONV];

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = 8'h00;
        if (req.addr == `BCR_CFG2_ADDR) begin
            rdata_next = cfg2_reg;
        end
        for (int i = 0; i < NCONV; i++) begin
            if (req.addr == 8'(`BCR_CFG1_BASE + i)) begin
                rdata_next = cfg1_reg[i];
            end
        end
    end

    wire cfg2_hit = req.wr && (req.addr == `BCR_CFG2_ADDR);

    // second register, reserved bits stored as written
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg2_reg <= `BCR_CFG2_RESET; // [R9]
            rdata    <= 8'h00;
        end else if (ce) begin
            if (cfg2_hit) begin
                cfg2_reg <= req.wdata; // [R9]
            end
            if (req.rd) begin
                rdata <= rdata_next;
            end
        end
    end

    // sensing is suspended in low-power without touching the bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            remote_output_sensing <= 2'h0;
        end else if (ce) begin
            remote_output_sensing[0] <= cfg2_reg[`BCR_SENSE0_BIT] && !conv[0].low_power; // [R11]
            remote_output_sensing[1] <= cfg2_reg[`BCR_SENSE1_BIT] && !conv[1].low_power; // [R12]
        end
    end

    for (genvar g = 0; g < NCONV; g++) begin : g_conv
        wire dis_n    = cfg1_reg[g][`BCR_DIS_N_BIT];
        wire fpwm     = cfg1_reg[g][`BCR_FPWM_BIT];
        // falling-slew discharge only counts outside low-power mode
        wire fs_act   = !cfg1_reg[g][`BCR_FSR_N_BIT] && !conv[g].low_power; // [R6]
        wire fs_force = fs_act && (conv[g].ramp_down || hold_reg[g] != 14'h0000); // [R7]
        wire force_ff = fpwm || fs_force; // [R4]
        wire hit1     = req.wr && (req.addr == 8'(`BCR_CFG1_BASE + g));

        // combinational so the switch opens in the enable cycle
        assign discharge_on[g] = !conv[g].enable && !dis_n; // [R1] [R2] [R14]

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                cfg1_reg[g]      <= CFG1_RESET;
                hold_reg[g]      <= 14'h0000;
                pulse_skip_en[g] <= 1'b0;
                ramp_rate[g]     <= `BCR_RATE_0;
            end else if (ce) begin
                if (hit1) begin
                    cfg1_reg[g] <= req.wdata;
                end
                // hold reloads through the ramp, counts down after target
                if (!fs_act) begin
                    hold_reg[g] <= 14'h0000;
                end else if (conv[g].ramp_down) begin
                    hold_reg[g] <= HOLD; // [R7]
                end else if (hold_reg[g] != 14'h0000) begin
                    hold_reg[g] <= hold_reg[g] - 14'h0001;
                end
                pulse_skip_en[g] <= !force_ff && conv[g].light_load; // [R3] [R8]
                ramp_rate[g] <= rate_decode(cfg1_reg[g][`BCR_RATE_HI:`BCR_RATE_LO]); // [R13]
            end
        end
    end

    // checks on converter zero and the shared registers
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    property p_dis_on;
        !conv[0].enable && !cfg1_reg[0][`BCR_DIS_N_BIT] |-> discharge_on[0];
    endproperty
    a_dis_on: assert property (p_dis_on) else $error("discharge not connected"); // [R1]
    property p_dis_off;
        cfg1_reg[0][`BCR_DIS_N_BIT] || conv[0].enable |-> !discharge_on[0];
    endproperty
    a_dis_off: assert property (p_dis_off) else $error("discharge wrongly connected"); // [R2]
    property p_fpwm;
        ce && cfg1_reg[0][`BCR_FPWM_BIT] |=> !pulse_skip_en[0];
    endproperty
    a_fpwm: assert property (p_fpwm) else $error("skip while fpwm set"); // [R4]
    property p_auto;
        ce && !cfg1_reg[0][`BCR_FPWM_BIT] && conv[0].low_power && conv[0].light_load
            |=> pulse_skip_en[0];
    endproperty
    a_auto: assert property (p_auto) else $error("no skip at light load"); // [R3]
    property p_lp;
        ce && conv[0].low_power && !cfg1_reg[0][`BCR_FPWM_BIT] && conv[0].ramp_down
            && conv[0].light_load |=> pulse_skip_en[0];
    endproperty
    a_lp: assert property (p_lp) else $error("falling slew active in low power"); // [R6]
    property p_hold;
        ce && conv[0].ramp_down && !conv[0].low_power && !cfg1_reg[0][`BCR_FSR_N_BIT]
            |=> hold_reg[0] == HOLD && !pulse_skip_en[0];
    endproperty
    a_hold: assert property (p_hold) else $error("hold not loaded"); // [R7]
    property p_noslew;
        ce && cfg1_reg[0][`BCR_FSR_N_BIT] && !cfg1_reg[0][`BCR_FPWM_BIT]
            && conv[0].ramp_down && conv[0].light_load |=> pulse_skip_en[0];
    endproperty
    a_noslew: assert property (p_noslew) else $error("skip blocked on ramp"); // [R8]
    property p_cfg2;
        ce && cfg2_hit ##1 ce && req.rd && req.addr == `BCR_CFG2_ADDR
            |=> rdata == $past(req.wdata, 2);
    endproperty
    a_cfg2: assert property (p_cfg2) else $error("second register readback"); // [R9]
    property p_sense0;
        ce |=> remote_output_sensing[0]
            == ($past(cfg2_reg[`BCR_SENSE0_BIT]) && !$past(conv[0].low_power));
    endproperty
    a_sense0: assert property (p_sense0) else $error("sense zero wrong"); // [R11]
    property p_sense1;
        ce |=> remote_output_sensing[1]
            == ($past(cfg2_reg[`BCR_SENSE1_BIT]) && !$past(conv[1].low_power));
    endproperty
    a_sense1: assert property (p_sense1) else $error("sense one wrong"); // [R12]
    property p_rate;
        ce && cfg1_reg[0][`BCR_RATE_HI:`BCR_RATE_LO] == 2'h3 |=> ramp_rate[0] == `BCR_RATE_3;
    endproperty
    a_rate: assert property (p_rate) else $error("rate decode wrong"); // [R13]
    property p_dis_en;
        conv[0].enable |-> !discharge_on[0];
    endproperty
    a_dis_en: assert property (p_dis_en) else $error("discharge while enabled"); // [R14]
    property p_rate0;
        ce && cfg1_reg[0][`BCR_RATE_HI:`BCR_RATE_LO] == 2'h0 |=> ramp_rate[0] == `BCR_RATE_0;
    endproperty
    a_rate0: assert property (p_rate0) else $error("slowest rate decode wrong"); // [R13]

    // the fixed-frequency hold must outlast the ramp by the full count
    property p_hold_keep;
        ce && hold_reg[0] != 14'h0000 && !cfg1_reg[0][`BCR_FSR_N_BIT] && !conv[0].low_power
            |=> !pulse_skip_en[0];
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("skip during hold"); // [R7]
    property p_hold_dec;
        ce && hold_reg[0] != 14'h0000 && !cfg1_reg[0][`BCR_FSR_N_BIT] && !conv[0].low_power
            && !conv[0].ramp_down |=> hold_reg[0] == $past(hold_reg[0]) - 14'h0001;
    endproperty
    a_hold_dec: assert property (p_hold_dec) else $error("hold not counting down"); // [R7]
    // low-power drops a pending hold so skipping is allowed at once
    property p_hold_lp;
        ce && conv[0].low_power |=> hold_reg[0] == 14'h0000;
    endproperty
    a_hold_lp: assert property (p_hold_lp) else $error("hold kept in low power"); // [R6]
    property p_rd2;
        ce && req.rd && req.addr == `BCR_CFG2_ADDR |=> rdata == $past(cfg2_reg);
    endproperty
    a_rd2: assert property (p_rd2) else $error("second register read wrong"); // [R9]

    // covers for the main scenarios
    c_hold: cover property (conv[0].ramp_down ##1 !conv[0].ramp_down && hold_reg[0] != 14'h0000);
    c_cfg2: cover property (cfg2_hit);
    c_lp:   cover property (conv[0].low_power && cfg2_reg[`BCR_SENSE0_BIT]);
    c_dis:  cover property (discharge_on[0]);
    c_skip: cover property (pulse_skip_en[0] && conv[0].ramp_down);
endmodule : bcr_config

// ### hdl/bcr_regs.svh
`ifndef BCR_REGS_SVH
`define BCR_REGS_SVH
// register byte addresses on the control port
`define BCR_CFG1_BASE     8'h1d
`define BCR_CFG2_ADDR     8'h22
// reset values
`define BCR_CFG2_RESET    8'h07
`define BCR_CFG1_RESET    8'h40
// field positions in the first configuration register
`define BCR_RATE_HI       7
`define BCR_RATE_LO       6
`define BCR_DIS_N_BIT     3
`define BCR_FPWM_BIT      2
`define BCR_FSR_N_BIT     0
// field positions in the second configuration register
`define BCR_SENSE0_BIT    2
`define BCR_SENSE1_BIT    1
// ramp rates in units of 0.01 mV/us
`define BCR_RATE_0        14'h055f
`define BCR_RATE_1        14'h0abe
`define BCR_RATE_2        14'h157c
`define BCR_RATE_3        14'h2710
// falling-slew fixed-frequency hold time and clock period
`define BCR_HOLD_NS       50000
`define BCR_CLK_NS        5
`endif

// ### hdl/bcr_pkg.sv
package bcr_pkg;
    // per-converter state seen by the configuration logic
    typedef struct packed {
        logic enable;
        logic low_power;
        logic ramp_down;
        logic light_load;
    } bcr_conv_s;
    // byte-wide register request from the control-port engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bcr_req_s;
    typedef logic [13:0] bcr_rate_t;
endpackage : bcr_pkg

// ### bench/bcr_host_model.sv
`timescale 1ns/1ps
module bcr_host_model (
    // clock
    input  wire logic         clock,
    // byte request toward the register port
    output bcr_pkg::bcr_req_s req
);
    import bcr_pkg::*;
    initial req = '0;
    // one write strobe, launched off the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 8'h22)
            v[7:3] = 5'h00;
        else
            v[1] = 1'b0;
        @(negedge clock);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(negedge clock);
        req = '0;
    endtask : wr
    // one read strobe, then idle so read data can settle
    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clock);
        req = '0;
        repeat (2) @(negedge clock);
    endtask : rd
    // write then read back on the very next edge, no idle cycle between
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 8'h22)
            v[7:3] = 5'h00;
        else
            v[1] = 1'b0;
        @(negedge clock);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(negedge clock);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clock);
        req = '0;
        repeat (2) @(negedge clock);
    endtask : wr_rd
endmodule : bcr_host_model

// ### bench/buck_regulator_config_regs_tb_top.sv
`timescale 1ns/1ps
module buck_regulator_config_regs_tb_top;
    import bcr_pkg::*;
    localparam int HOLD = 20;
    logic              clock;
    logic              rst;
    logic              ce;
    bcr_req_s          req;
    logic [7:0]        rdata;
    bcr_conv_s         conv [4];
    logic [3:0]        dis;
    logic [3:0]        skip;
    logic [1:0]        sense;
    bcr_rate_t         rate [4];
    logic [7:0]        exp_q [$];
    int                fail_count = 0;
    int                n_checks = 0;
    bcr_rate_t         rtab [4] = '{14'h055f, 14'h0abe, 14'h157c, 14'h2710};
    bcr_host_model host (.clock(clock), .req(req));
    bcr_config #(.NCONV(4), .HOLD_CYC(HOLD)) DUT (.clock(clock), .rst(rst), .ce(ce),
        .req(req), .rdata(rdata), .conv(conv), .discharge_on(dis),
        .pulse_skip_en(skip), .remote_output_sensing(sense), .ramp_rate(rate));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    // the driver notes the expected byte before the read goes out
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask : rd_exp
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    // read data is taken one and a half cycles after the strobe edge
    always @(posedge clock) begin
        if (req.rd === 1'b1) begin
            @(negedge clock);
            @(negedge clock);
            check("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
        end
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge clock);
        $display("Error run_length expected %0d seen %0d", 4999, 5000);
        fail_count++;
        final_report();
    end
    initial begin
        void'($urandom(71));
        rst = 1'b1;
        ce = 1'b1;
        foreach (conv[i]) conv[i] = '0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        tick(1);
        check("sense", 16'h0003, 16'(sense));
        rd_exp(8'h22, 8'h07);
        rd_exp(8'h1d, 8'h40);
        rd_exp(8'h30, 8'h00);
        for (int k = 0; k < 4; k++) begin
            foreach (conv[i]) conv[i].enable = 1'($urandom);
            #1;
            foreach (conv[i]) check("dis", 16'(!conv[i].enable), 16'(dis[i]));
        end
        // each converter gets its own ramp code, discharge off, fs bit set
        for (int c = 0; c < 4; c++) begin
            host.wr(8'h1d + 8'(c), 8'(c << 6) | 8'h09);
            tick(1);
            check("rate", 16'(rtab[c]), 16'(rate[c]));
            conv[c].enable = ~conv[c].enable;
            #1 check("dis", 16'h0000, 16'(dis[c]));
        end
        conv[0].light_load = 1'b1;
        conv[0].ramp_down = 1'b1;
        tick(2);
        check("skip", 16'h0001, 16'(skip[0]));
        host.wr(8'h1d, 8'h0d);
        tick(2);
        check("skip", 16'h0000, 16'(skip[0]));
        host.wr(8'h1d, 8'h08);
        tick(2);
        check("skip", 16'h0000, 16'(skip[0]));
        conv[0].low_power = 1'b1;
        tick(2);
        check("skip", 16'h0001, 16'(skip[0]));
        check("sense", 16'h0002, 16'(sense));
        conv[0].low_power = 1'b0;
        tick(2);
        conv[0].ramp_down = 1'b0;
        tick(HOLD - 3);
        check("skip", 16'h0000, 16'(skip[0]));
        tick(6);
        check("skip", 16'h0001, 16'(skip[0]));
        conv[1].low_power = 1'b1;
        host.wr(8'h22, 8'h04);
        tick(2);
        check("sense", 16'h0001, 16'(sense));
        conv[1].low_power = 1'b0;
        host.wr(8'h22, 8'h02);
        tick(2);
        check("sense", 16'h0002, 16'(sense));
        rd_exp(8'h22, 8'h02);
        // back-to-back write and read of the second register
        exp_q.push_back(8'h05);
        host.wr_rd(8'h22, 8'h05);
        check("sense", 16'h0001, 16'(sense));
        // a write while the clock enable is low must be dropped
        ce = 1'b0;
        host.wr(8'h22, 8'h02);
        ce = 1'b1;
        rd_exp(8'h22, 8'h05);
        // shutdown in mid-run restores both registers
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
        tick(1);
        check("sense", 16'h0003, 16'(sense));
        rd_exp(8'h22, 8'h07);
        rd_exp(8'h1d, 8'h40);
        tick(4);
        if (exp_q.size() != 0) begin
            $display("Error exp_q expected %0d seen %0d", 0, exp_q.size());
            fail_count++;
        end
        final_report();
    end
endmodule : buck_regulator_config_regs_tb_top
